//--- rtl/pem_port_ctrl.sv
// Port pin mode, alternate function and external interrupt 2 control
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module pem_port_ctrl
   import pem_pkg::*;
#(
   parameter int unsigned SLOW_DIV = SLOW_CYCLES,
   parameter int unsigned FAST_DIV = FAST_CYCLES
)(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]      o_wb_dat,
   output logic             o_wb_ack,
   // Oscillator clocks for the alternate outputs
   input  wire logic        i_rc_adc_clk,
   input  wire logic        i_low_speed_clk,
   input  wire logic        i_high_speed_clk,
   // Port pads
   input  wire logic [3:0]  i_pad_in,
   output pem_pads_t        o_pads,
   // Interrupt
   output logic             o_ext_irq2_request,
   output logic             o_irq
);

   // ************************************************************************
   // State
   // ************************************************************************
   typedef struct packed {
      logic [3:0]  mode;      // Pin 3 / pin 2 mode fields
      logic [3:0]  alt;       // Alternate function select
      logic [3:0]  dir;       // 1 = output
      logic [3:0]  data;      // Port data latch
      logic [3:0]  stat;      // Sticky events, write one to clear
      logic [3:0]  mask;      // Interrupt enables
      logic        ack;
      logic [31:0] rdat;
   } pem_state_t;

   pem_state_t s_r;
   pem_state_t s_nxt;

   logic       req;
   logic       wr_lo;
   logic       smp_change;
   logic [3:0] stat_set;
   logic [3:0] stat_clr;
   logic [3:0] alt_clks;
   logic [7:0] pin_modes;

   // Register hit for a write on the low byte lane
   function automatic logic wr_hit(input logic wr, input logic [7:0] adr, input logic [7:0] reg_adr);
      wr_hit = wr && (adr == reg_adr);
   endfunction

   // Read word of a register address; unmapped reads give zero
   function automatic logic [31:0] rd_word(input logic [7:0] adr, input pem_state_t s,
                                           input logic [3:0] pins);
      case (adr)
         ADR_MODE: rd_word = {28'h000_0000, s.mode};
         ADR_ALT:  rd_word = {28'h000_0000, s.alt};
         ADR_DIR:  rd_word = {28'h000_0000, s.dir};
         ADR_DATA: rd_word = {28'h000_0000, s.data};
         ADR_PINS: rd_word = {28'h000_0000, pins};
         ADR_STAT: rd_word = {28'h000_0000, s.stat};
         ADR_MASK: rd_word = {28'h000_0000, s.mask};
         default:  rd_word = RD_ZERO;
      endcase
   endfunction

   // Bus request and the write strobe of the only used byte lane
   assign req   = i_wb_cyc & i_wb_stb & ~s_r.ack;
   assign wr_lo = req & i_wb_we & i_wb_sel[0];

   // ************************************************************************
   // Register file and events
   // ************************************************************************
   always_comb begin
      s_nxt     = s_r;
      stat_set  = '0;
      stat_clr  = '0;
      s_nxt.ack = req;                                   // One wait state, then ack
      if (req && !i_wb_we) begin
         s_nxt.rdat = rd_word(i_wb_adr, s_r, i_pad_in);
      end
      if (wr_hit(wr_lo, i_wb_adr, ADR_MODE)) begin
         s_nxt.mode = i_wb_dat[3:0];
      end
      if (wr_hit(wr_lo, i_wb_adr, ADR_ALT)) begin
         s_nxt.alt = i_wb_dat[3:0];
      end
      if (wr_hit(wr_lo, i_wb_adr, ADR_DIR)) begin
         s_nxt.dir = i_wb_dat[3:0];
      end
      if (wr_hit(wr_lo, i_wb_adr, ADR_DATA)) begin
         s_nxt.data = i_wb_dat[3:0];
      end
      if (wr_hit(wr_lo, i_wb_adr, ADR_MASK)) begin
         s_nxt.mask = i_wb_dat[3:0];
      end
      if (wr_hit(wr_lo, i_wb_adr, ADR_STAT)) begin
         stat_clr = i_wb_dat[3:0];
      end
      // A new event in the clearing cycle survives the clear
      stat_set[STAT_IRQ2_BIT] = smp_change;
      s_nxt.stat = (s_r.stat & ~stat_clr) | stat_set;
   end

   // State register; reset clears the alternate select among the rest
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r.mode <= MODE_RST;
         s_r.alt  <= ALT_RST;
         s_r.dir  <= DIR_RST;
         s_r.data <= DATA_RST;
         s_r.stat <= STAT_RST;
         s_r.mask <= MASK_RST;
         s_r.ack  <= 1'b0;
         s_r.rdat <= RD_ZERO;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Bus outputs
   assign o_wb_ack = s_r.ack;
   assign o_wb_dat = s_r.rdat;

   // ************************************************************************
   // Interrupt 2 sampling
   // ************************************************************************
   pem_irq_sampler #(
      .SLOW_DIV (SLOW_DIV),
      .FAST_DIV (FAST_DIV)
   ) u_sampler (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_fast_sel (s_r.alt[RATE_BIT] == PEM_RATE_4KHZ),
      .i_pin      (i_pad_in[IRQ_PIN]),
      .o_tick     (),
      .o_change   (smp_change)
   );

   // Request pulse and masked level interrupt
   assign o_ext_irq2_request = smp_change;
   assign o_irq              = |(s_r.stat & s_r.mask);

   // ************************************************************************
   // Pad drivers
   // ************************************************************************
   // Clock sources per pin; pin 3 has no clock output
   assign alt_clks  = {1'b0, i_high_speed_clk, i_low_speed_clk, i_rc_adc_clk};
   assign pin_modes = {mode_field(s_r.mode, PIN3_MODE_LSB),
                       mode_field(s_r.mode, PIN2_MODE_LSB),
                       LOW_PIN_MODE, LOW_PIN_MODE};

   for (genvar p = 0; p < 4; p++) begin : g_pin
      pem_pin_drv u_drv (
         .i_mode      (pin_modes[2*p +: 2]),
         .i_dir_out   (s_r.dir[p]),
         .i_force_out ((p == FORCED_PIN) && s_r.alt[FORCED_PIN]),
         .i_alt_en    ((p != IRQ_PIN) && s_r.alt[p]),
         .i_alt_clk   (alt_clks[p]),
         .i_data      (s_r.data[p]),
         .o_oe        (o_pads.oe[p]),
         .o_out       (o_pads.out[p]),
         .o_pull_up   (o_pads.pull_up[p]),
         .o_pull_dn   (o_pads.pull_dn[p])
      );
   end

   // ************************************************************************
   // Checks
   // ************************************************************************
   a_mode_pin3: assert property (@(posedge i_clk) disable iff (i_rst)
      (req && i_wb_we && i_wb_sel[0] && i_wb_adr == ADR_MODE)
      |=> s_r.mode[3:2] == $past(i_wb_dat[3:2])) else $error("pin 3 mode not written");

   a_mode_pin2: assert property (@(posedge i_clk) disable iff (i_rst)
      (req && i_wb_we && i_wb_sel[0] && i_wb_adr == ADR_MODE)
      |=> s_r.mode[1:0] == $past(i_wb_dat[1:0])) else $error("pin 2 mode not written");

   a_input_pulls: assert property (@(posedge i_clk) disable iff (i_rst)
      !s_r.dir[3] |-> (o_pads.pull_dn[3] == (s_r.mode[3:2] == IN_PULL_DN)
                      && o_pads.pull_up[3] == (s_r.mode[3:2] == IN_PULL_UP)
                      && !o_pads.oe[3])) else $error("input pull wrong");

   a_out_drive: assert property (@(posedge i_clk) disable iff (i_rst)
      (s_r.dir[2] && !s_r.alt[2] && s_r.mode[1:0] == OUT_NDRAIN)
      |-> (!o_pads.out[2] && o_pads.oe[2] == !s_r.data[2])) else $error("open drain wrong");

   a_reset_clear: assert property (@(posedge i_clk)
      i_rst |-> s_r.alt == ALT_RST) else $error("alt select not cleared");

   a_pin1_forced: assert property (@(posedge i_clk) disable iff (i_rst)
      s_r.alt[1] |-> (o_pads.oe[1] && o_pads.out[1] == i_low_speed_clk))
      else $error("pin 1 clock not driven");

   a_clk_replace: assert property (@(posedge i_clk) disable iff (i_rst)
      (s_r.alt[2] && s_r.dir[2] && s_r.mode[1:0] == OUT_CMOS)
      |-> o_pads.out[2] == i_high_speed_clk) else $error("pin 2 clock not driven");

   a_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
      smp_change |=> s_r.stat[STAT_IRQ2_BIT]) else $error("interrupt flag not set");

   a_irq_level: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(s_r.stat[STAT_IRQ2_BIT]) && s_r.mask[STAT_IRQ2_BIT] |-> o_irq)
      else $error("interrupt not raised");

   a_ack_drop: assert property (@(posedge i_clk) disable iff (i_rst)
      o_wb_ack |=> !o_wb_ack) else $error("ack held too long");

endmodule
`default_nettype wire

//--- rtl/pem_pkg.sv
// Shared constants and types for the port mode and alternate function block
// ****************************************************************************
// ****************************************************************************
package pem_pkg;

   // ************************************************************************
   // Timing
   // ************************************************************************
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned SLOW_HZ     = 128;
   localparam int unsigned FAST_HZ     = 4000;
   // Longest wait rounds down to whole cycles
   localparam int unsigned SLOW_CYCLES = CLK_HZ / SLOW_HZ;
   localparam int unsigned FAST_CYCLES = CLK_HZ / FAST_HZ;

   // ************************************************************************
   // Register map (byte addresses)
   // ************************************************************************
   localparam logic [7:0] ADR_MODE  = 8'h00;
   localparam logic [7:0] ADR_ALT   = 8'h04;
   localparam logic [7:0] ADR_DIR   = 8'h08;
   localparam logic [7:0] ADR_DATA  = 8'h0C;
   localparam logic [7:0] ADR_PINS  = 8'h10;
   localparam logic [7:0] ADR_STAT  = 8'h14;
   localparam logic [7:0] ADR_MASK  = 8'h18;

   // ************************************************************************
   // Field positions and reset values
   // ************************************************************************
   localparam int unsigned PIN3_MODE_LSB = 2;
   localparam int unsigned PIN2_MODE_LSB = 0;
   localparam int unsigned RATE_BIT      = 3;
   localparam int unsigned STAT_IRQ2_BIT = 0;
   localparam int unsigned IRQ_PIN       = 3;
   localparam int unsigned FORCED_PIN    = 1;
   localparam logic [3:0]  MODE_RST      = 4'h0;
   localparam logic [3:0]  ALT_RST       = 4'h0;
   localparam logic [3:0]  DIR_RST       = 4'h0;
   localparam logic [3:0]  DATA_RST      = 4'h0;
   localparam logic [3:0]  STAT_RST      = 4'h0;
   localparam logic [3:0]  MASK_RST      = 4'h0;
   localparam logic [31:0] RD_ZERO       = 32'h0000_0000;

   // ************************************************************************
   // Mode encodings
   // ************************************************************************
   localparam logic [1:0] IN_PULL_DN   = 2'h0;
   localparam logic [1:0] IN_PULL_UP   = 2'h2;
   localparam logic [1:0] OUT_CMOS     = 2'h0;
   localparam logic [1:0] OUT_NDRAIN   = 2'h1;
   localparam logic [1:0] OUT_PDRAIN   = 2'h2;
   localparam logic [1:0] OUT_HIZ      = 2'h3;
   // Pins 1 and 0 have no mode field here: fixed push-pull / pull-down
   localparam logic [1:0] LOW_PIN_MODE = 2'h0;

   // Sampling rate choice
   typedef enum logic {PEM_RATE_128HZ, PEM_RATE_4KHZ} pem_rate_t;

   // Pad controls of the four port pins
   typedef struct packed {
      logic [3:0] oe;
      logic [3:0] out;
      logic [3:0] pull_up;
      logic [3:0] pull_dn;
   } pem_pads_t;

   // Mode field of one pin out of the pin 3 / pin 2 register
   function automatic logic [1:0] mode_field(input logic [3:0] reg_v, input int unsigned lsb);
      mode_field = reg_v[lsb +: 2];
   endfunction

endpackage

//--- rtl/pem_pin_drv.sv
// Pad driver of one port pin: direction, drive type, pulls and clock output
`timescale 1ns/1ps
`default_nettype none
module pem_pin_drv
   import pem_pkg::*;
(
   // Settings
   input  wire logic [1:0] i_mode,
   input  wire logic       i_dir_out,
   input  wire logic       i_force_out,
   // Data sources
   input  wire logic       i_alt_en,
   input  wire logic       i_alt_clk,
   input  wire logic       i_data,
   // Pad
   output logic            o_oe,
   output logic            o_out,
   output logic            o_pull_up,
   output logic            o_pull_dn
);

   logic drive_val;
   logic is_out;

   // ************************************************************************
   // Drive decode (no state: the pad follows the settings directly)
   // ************************************************************************
   always_comb begin
      drive_val = i_alt_en ? i_alt_clk : i_data;
      is_out    = i_dir_out | i_force_out;
      o_oe      = 1'b0;
      o_out     = 1'b0;
      o_pull_up = 1'b0;
      o_pull_dn = 1'b0;
      if (is_out) begin
         case (i_mode)
            OUT_CMOS: begin
               o_oe  = 1'b1;
               o_out = drive_val;
            end
            OUT_NDRAIN: begin
               o_oe  = ~drive_val;                        // Sinks only
               o_out = 1'b0;
            end
            OUT_PDRAIN: begin
               o_oe  = drive_val;                         // Sources only
               o_out = 1'b1;
            end
            default: begin
               o_oe  = 1'b0;                              // High impedance
            end
         endcase
      end else begin
         o_pull_dn = (i_mode == IN_PULL_DN);
         o_pull_up = (i_mode == IN_PULL_UP);
      end
   end

endmodule
`default_nettype wire

//--- rtl/pem_irq_sampler.sv
// Sampling clock and level change detector for the pin 3 external interrupt
`timescale 1ns/1ps
`default_nettype none
module pem_irq_sampler
   import pem_pkg::*;
#(
   parameter int unsigned SLOW_DIV = SLOW_CYCLES,
   parameter int unsigned FAST_DIV = FAST_CYCLES
)(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Control and pin
   input  wire logic i_fast_sel,
   input  wire logic i_pin,
   // Events
   output logic      o_tick,
   output logic      o_change
);

   localparam int unsigned CW = $clog2(SLOW_DIV + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          primed;
      logic          last;
      logic          tick;
      logic          change;
   } pem_smp_state_t;

   pem_smp_state_t s_r;
   pem_smp_state_t s_nxt;
   logic [CW-1:0]  limit;

   // ************************************************************************
   // Sampling divider and edge compare
   // ************************************************************************
   always_comb begin
      limit        = i_fast_sel ? CW'(FAST_DIV - 1) : CW'(SLOW_DIV - 1);
      s_nxt        = s_r;
      s_nxt.tick   = 1'b0;
      s_nxt.change = 1'b0;
      // A count past the new limit after a rate switch wraps at once
      if (s_r.cnt >= limit) begin
         s_nxt.cnt    = '0;
         s_nxt.tick   = 1'b1;
         s_nxt.last   = i_pin;
         s_nxt.primed = 1'b1;
         s_nxt.change = s_r.primed & (i_pin != s_r.last);
      end else begin
         s_nxt.cnt = s_r.cnt + CW'(1);
      end
   end

   // State register
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_tick   = s_r.tick;
   assign o_change = s_r.change;

   // ************************************************************************
   // Checks
   // ************************************************************************
   logic [CW-1:0] gap_r;
   logic          fast_run_r;

   // Gap since the last tick, and whether the running period was all at the fast rate
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         gap_r      <= '0;
         fast_run_r <= 1'b0;
      end else begin
         gap_r <= s_r.tick ? '0 : gap_r + CW'(1);
         if (!i_fast_sel) begin
            fast_run_r <= 1'b0;
         end else if (s_r.tick) begin
            fast_run_r <= 1'b1;
         end
      end
   end

   a_sample_gap: assert property (@(posedge i_clk) disable iff (i_rst)
      gap_r < CW'(SLOW_DIV + 1)) else $error("sampling period too long");

   a_fast_period: assert property (@(posedge i_clk) disable iff (i_rst)
      (fast_run_r && s_r.tick) |-> gap_r == CW'(FAST_DIV - 1))
      else $error("fast sampling period wrong");

endmodule
`default_nettype wire

//--- test/pem_board.sv
// Board circuitry model on the four port pins
`timescale 1ns/1ps
`default_nettype none
module pem_board
   import pem_pkg::*;
(
   // Clock
   input  wire logic       i_clk,
   // Device pads and board drive
   input  wire pem_pads_t  i_pads,
   input  wire logic [3:0] i_drv_en,
   input  wire logic [3:0] i_drv_lvl,
   // Resolved pin levels
   output logic [3:0]      o_level
);
   logic [3:0] wander_r = 4'h0;

   // A pin nobody holds and nothing pulls changes every cycle
   always_ff @(posedge i_clk) begin
      wander_r <= ~wander_r;
   end

   // Device drive first, then the board, then the pad pulls
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         if (i_pads.oe[b]) begin
            o_level[b] = i_pads.out[b];
         end else if (i_drv_en[b]) begin
            o_level[b] = i_drv_lvl[b];
         end else if (i_pads.pull_up[b] != i_pads.pull_dn[b]) begin
            o_level[b] = i_pads.pull_up[b];
         end else begin
            o_level[b] = wander_r[b];
         end
      end
   end
endmodule
`default_nettype wire

//--- test/pem_port_ctrl_tb_top.sv
// Self-checking bench for the port mode and alternate function block
`timescale 1ns/1ps
`default_nettype none
module pem_port_ctrl_tb_top
   import pem_pkg::*;
;
   localparam int SLOW = 40;
   localparam int FAST = 8;
   logic        i_clk = 1'b0;
   logic        rst = 1'b0;
   logic        cyc, stb, we, ack, rc, ls, hs, req, irq;
   logic [7:0]  adr, lf;
   logic [3:0]  sel, pad_in, drv_en, drv_lvl, md;
   logic [31:0] dat, rdat;
   pem_pads_t   pads;
   logic [31:0] exp_q[$];
   int          num_errors = 0;
   int          comparisons = 0;
   logic        d, e;
   int          n;

   // Free running 50 MHz clock
   always #10 i_clk = ~i_clk;

   pem_port_ctrl #(.SLOW_DIV(SLOW), .FAST_DIV(FAST)) u_dut (.i_clk(i_clk), .i_rst(rst),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_rc_adc_clk(rc),
      .i_low_speed_clk(ls), .i_high_speed_clk(hs), .i_pad_in(pad_in), .o_pads(pads),
      .o_ext_irq2_request(req), .o_irq(irq));

   pem_board u_board (.i_clk(i_clk), .i_pads(pads), .i_drv_en(drv_en),
      .i_drv_lvl(drv_lvl), .o_level(pad_in));

   // ************************************************************************
   // Reporting and bus tasks
   // ************************************************************************
   task automatic close_out();
      if (num_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic miss(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask

   task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         miss(m);
      end
   endtask

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Classic single cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] v);
      int k;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      sel <= 4'hF;
      dat <= {28'h000_0000, v};
      k = 0;
      do begin
         @(posedge i_clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (k >= 50) begin
         miss("no bus answer");
         close_out();
      end else begin
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [3:0] v);
      exp_q.push_back({28'h000_0000, v});
      wb(1'b0, a, 4'h0);
   endtask

   // Read answers are matched against the oldest note
   always @(posedge i_clk) begin
      if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0) begin
         comparisons++;
         if (exp_q.size() == 0) begin
            miss("read with no note");
         end else if (rdat !== exp_q.pop_front()) begin
            miss("read data");
         end
      end
   end

   // ************************************************************************
   // Main sequence
   // ************************************************************************
   initial begin
      {cyc, stb, we, rc, ls, hs} = 6'h00;
      rst <= 1'b1;
      {adr, sel, dat, drv_en, drv_lvl} = '0;
      lf = 8'h3F;
      repeat (12) @(posedge i_clk);
      rst <= 1'b0;
      rd(ADR_MODE, MODE_RST);
      rd(ADR_ALT, ALT_RST);
      rd(ADR_DIR, DIR_RST);
      rd(ADR_MASK, MASK_RST);
      rd(8'h1C, 4'h0);
      for (int i = 0; i < 6; i++) begin
         lf = lfsr(lf);
         wb(1'b1, ADR_MODE, lf[3:0]);
         rd(ADR_MODE, lf[3:0]);
         wb(1'b1, ADR_ALT, lf[7:4]);
         rd(ADR_ALT, lf[7:4]);
      end
      wb(1'b1, ADR_ALT, 4'h0);
      wb(1'b1, ADR_DIR, 4'h0);
      // Input meanings of every mode code
      for (int m = 0; m < 4; m++) begin
         md = 4'(m);
         wb(1'b1, ADR_MODE, {md[1:0], md[1:0]});
         @(negedge i_clk);
         chk(pads.pull_dn, {md[1:0] == 2'h0, md[1:0] == 2'h0, 2'b11}, "pull down");
         chk(pads.pull_up, {md[1:0] == 2'h2, md[1:0] == 2'h2, 2'b00}, "pull up");
         chk(pads.oe, 4'h0, "input drives");
         repeat (4) @(posedge i_clk);
         if (!md[0]) rd(ADR_PINS, {md[1], md[1], 2'b00});
      end
      // Output meanings with both data levels
      wb(1'b1, ADR_DIR, 4'hC);
      for (int k = 0; k < 8; k++) begin
         md = 4'(k);
         d = md[2];
         wb(1'b1, ADR_DATA, {d, d, 2'b00});
         wb(1'b1, ADR_MODE, {md[1:0], md[1:0]});
         @(negedge i_clk);
         e = (md[1:0] == OUT_CMOS) | (md[1:0] == OUT_NDRAIN && !d) | (md[1:0] == OUT_PDRAIN && d);
         chk(pads.oe, {e, e, 2'b00}, "output enable");
         if (e) chk(pads.out & 4'hC, {d, d, 2'b00}, "output level");
      end
      // Clock outputs in place of the data latch
      wb(1'b1, ADR_DATA, 4'h0);
      wb(1'b1, ADR_MODE, {OUT_HIZ, OUT_CMOS});
      wb(1'b1, ADR_DIR, 4'h5);
      wb(1'b1, ADR_ALT, 4'h7);
      for (int i = 0; i < 6; i++) begin
         lf = lfsr(lf);
         @(posedge i_clk);
         {hs, ls, rc} <= lf[2:0];
         @(negedge i_clk);
         chk({1'b0, pads.oe[2:0]}, 4'h7, "clock drive");
         chk({1'b0, pads.out[2:0]}, {1'b0, lf[2:0]}, "clock level");
      end
      wb(1'b1, ADR_DIR, 4'h0);
      @(negedge i_clk);
      chk({1'b0, pads.oe[2:0]}, 4'h2, "pin one forced out");
      wb(1'b1, ADR_DIR, 4'h4);
      wb(1'b1, ADR_MODE, {OUT_HIZ, OUT_NDRAIN});
      hs <= 1'b1;
      @(negedge i_clk);
      chk({3'b000, pads.oe[2]}, 4'h0, "open drain clock high");
      @(posedge i_clk);
      hs <= 1'b0;
      @(negedge i_clk);
      chk({3'b000, pads.oe[2]}, 4'h1, "open drain clock low");
      // Clock high against a low latch, so only the switch back can enable the drain
      @(posedge i_clk);
      hs <= 1'b1;
      wb(1'b1, ADR_ALT, 4'h0);
      @(negedge i_clk);
      chk({3'b000, pads.oe[2]}, 4'h1, "plain port drive");
      // Pin 3 interrupt at both sampling rates
      wb(1'b1, ADR_DIR, 4'h0);
      wb(1'b1, ADR_MODE, 4'h4);
      drv_en <= 4'h8;
      wb(1'b1, ADR_MASK, 4'h1);
      for (int r = 0; r < 2; r++) begin
         wb(1'b1, ADR_ALT, {r[0], 3'b000});
         repeat (100) @(posedge i_clk);
         wb(1'b1, ADR_STAT, 4'h1);
         rd(ADR_STAT, 4'h0);
         drv_lvl <= ~drv_lvl;
         n = 0;
         do begin
            @(posedge i_clk);
            n++;
         end while (req !== 1'b1 && n < (r ? FAST : SLOW) + 3);
         chk({3'b000, req}, 4'h1, "request late");
         if (req !== 1'b1) begin
            close_out();
         end
         rd(ADR_STAT, 4'h1);
         @(negedge i_clk);
         chk({3'b000, irq}, 4'h1, "irq missing");
         wb(1'b1, ADR_MASK, 4'h0);
         @(negedge i_clk);
         chk({3'b000, irq}, 4'h0, "irq not masked");
         wb(1'b1, ADR_MASK, 4'h1);
      end
      // Reset in mid-run must clear the rate bit left set above
      @(posedge i_clk);
      rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      rst <= 1'b0;
      rd(ADR_ALT, ALT_RST);
      rd(ADR_MASK, MASK_RST);
      repeat (3) @(posedge i_clk);
      close_out();
   end
endmodule
`default_nettype wire
